// File: core/pc_stack_pkg.sv
// constants, types and helpers shared by the program counter and return stack
package pc_stack_pkg;
  localparam int PC_W      = 21;
  localparam int UPPER_W   = 5;
  localparam int BYTE_W    = 8;
  localparam int WORD_W    = 16;
  localparam int PTR_W     = 5;
  localparam int STK_DEPTH = 31;
  // 21-bit counter spans the whole 2-Mbyte program space
  localparam logic [PC_W:0]    SPACE_BYTES   = 22'h200000;
  localparam logic [PC_W-1:0]  MEM_128K      = 21'h020000;
  localparam logic [PC_W-1:0]  MEM_64K       = 21'h010000;
  localparam logic [PC_W-1:0]  CFG_AREA      = 21'h000008;
  localparam logic [PC_W-1:0]  CFG_STEP      = 21'h000002;
  localparam logic [PC_W-1:0]  VEC_RESET     = 21'h000000;
  localparam logic [PC_W-1:0]  VEC_HIGH      = 21'h000008;
  localparam logic [PC_W-1:0]  VEC_LOW       = 21'h000018;
  localparam logic [PC_W-1:0]  PC_STEP       = 21'h000002;
  localparam logic [PC_W-1:0]  PC_ALIGN      = 21'h1ffffe;
  localparam logic [BYTE_W-1:0] LOW_ALIGN    = 8'hfe;
  localparam logic [PTR_W-1:0] STK_EMPTY     = 5'h00;
  localparam logic [PTR_W-1:0] STK_LAST_FREE = 5'h1e;
  localparam logic [PTR_W-1:0] STK_TOP       = 5'h1f;
  localparam logic [PTR_W-1:0] STK_STEP      = 5'h01;
  localparam int PTR_FULL_BIT  = 7;
  localparam int PTR_UNF_BIT   = 6;
  localparam int FAULT_EN_BIT  = 0;
  // erased configuration reads as ones, so the fault reset starts enabled
  localparam logic [WORD_W-1:0] CFG_RESET    = 16'hffff;
  localparam logic [WORD_W-1:0] FETCH_ZERO   = 16'h0000;
  localparam logic [PC_W-1:0]  PC_ZERO       = 21'h000000;
  localparam logic [BYTE_W-1:0] BYTE_ZERO    = 8'h00;

  typedef enum {CFG_WORD1, CFG_WORD2, CFG_WORD3, CORE_RUN} load_state_t;

  function automatic logic [PC_W-1:0] pc_add(input logic [PC_W-1:0] pc, input logic [PC_W-1:0] step);
    logic [PC_W:0] sum;
    sum = {1'b0, pc} + {1'b0, step};
    return sum[PC_W-1:0] & PC_ALIGN;
  endfunction
endpackage

// File: core/stack_port_if.sv
// write and read port between the stack control and the stack storage
`timescale 1ns/1ps
`default_nettype none
interface stack_port_if;
  import pc_stack_pkg::*;
  logic             we;
  logic [PTR_W-1:0] widx;
  logic [PC_W-1:0]  wdata;
  logic [PTR_W-1:0] ridx;
  logic [PC_W-1:0]  rdata;
  modport owner (output we, output widx, output wdata, output ridx, input rdata);
  modport store (input we, input widx, input wdata, input ridx, output rdata);
endinterface
`default_nettype wire

// File: core/return_stack_store.sv
// 31 x 21-bit return address storage, entries 1..31, no entry at index 0
`timescale 1ns/1ps
`default_nettype none
module return_stack_store
  import pc_stack_pkg::*;
#(
  parameter int DEPTH = STK_DEPTH
) (
  // clock
  input wire logic    clk,
  // stack port
  stack_port_if.store port
);
  logic [PC_W-1:0] entry [1:DEPTH]; // RQ12

  // index zero is only the empty value, so writes there are dropped
  always_ff @(posedge clk) begin
    if (port.we && port.widx != STK_EMPTY) begin
      entry[port.widx] <= port.wdata;
    end
  end

  assign port.rdata = (port.ridx == STK_EMPTY) ? PC_ZERO : entry[port.ridx];
endmodule
`default_nettype wire

// File: core/program_fetch_gate.sv
// forces fetched data to zero outside implemented program memory
`timescale 1ns/1ps
`default_nettype none
module program_fetch_gate
  import pc_stack_pkg::*;
#(
  parameter logic [PC_W-1:0] MEM_BYTES = MEM_128K
) (
  // address and raw memory data
  input  wire logic [PC_W-1:0]   addr,
  input  wire logic [WORD_W-1:0] raw_data,
  // gated data
  output logic      [WORD_W-1:0] data
);
  // zero word executes as a no-operation
  assign data = (addr < MEM_BYTES) ? raw_data : FETCH_ZERO; // RQ2
endmodule
`default_nettype wire

// File: core/program_counter_return_stack.sv
// program counter, latches, configuration copy and hardware return stack
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// (RQ1) 21-bit program counter covers 2-Mbyte space; program fetch bus separate from data.
// (RQ2) fetches beyond implemented memory return all zeros, a no-operation.
// (RQ3) every reset loads the counter with 0000h.
// (RQ4) high-priority interrupt goes to 0008h, low-priority to 0018h.
// (RQ5) top four memory words copied into configuration registers on reset.
// (RQ6) configuration bytes ascend from word one low byte; word four unused.
// (RQ7) counter kept as three bytes; high and upper changed only through latches.
// (RQ8) writing the low byte loads high and upper bytes from latches.
// (RQ9) reading the low byte copies high and upper bytes into latches.
// (RQ10) counter bit zero stays zero; sequential fetch adds two.
// (RQ11) call, goto and branch load counter directly, ignoring latches.
// (RQ12) stack is separate 31 by 21-bit store with 5-bit pointer.
// (RQ13) push on call and interrupt; pop on returns and enabled unlink ops.
// (RQ14) calls and returns leave both latches unchanged.
// (RQ15) push increments pointer first, then writes return address there.
// (RQ16) pop loads counter from selected entry, then decrements pointer.
// (RQ17) pointer is zero after reset; zero has no entry behind it.
// (RQ18) only selected entry visible via three byte registers; pointer read/write.
// (RQ19) flags show stack full or overflowed, and underflowed.
// (RQ20) software disables interrupts while touching stack registers.
// (RQ21) top entry shows pushed value; software writes there feed next return.
// (RQ22) without fault reset, 31st push sets full; pointer then sticks at 31.
// (RQ23) with fault reset, 31st push stores address, sets full, resets device.
// (RQ24) pop at zero loads zero, sets underflow, may reset device.
// (RQ25) full bit 7 and underflow bit 6 cleared only by software or power-on.
// (RQ26) after a pointer write the top entry shows the new entry.
module program_counter_return_stack
  import pc_stack_pkg::*;
#(
  parameter logic [PC_W-1:0] MEM_BYTES = MEM_128K
) (
  // clock and power-on reset
  input  wire logic                clk,
  input  wire logic                resetn,
  // other device resets
  input  wire logic                soft_reset,
  // decoder requests
  input  wire logic                op_advance,
  input  wire logic                op_call,
  input  wire logic                op_relative_call,
  input  wire logic                op_goto,
  input  wire logic                op_return,
  input  wire logic                op_return_with_literal,
  input  wire logic                op_return_from_interrupt,
  input  wire logic                op_add_and_unlink,
  input  wire logic                op_subtract_and_unlink,
  input  wire logic                extended_enable,
  input  wire logic                int_high_ack,
  input  wire logic                int_low_ack,
  input  wire logic [PC_W-1:0]     target_addr,
  // byte register accesses
  input  wire logic                pc_low_wr,
  input  wire logic                pc_low_rd,
  input  wire logic                pc_high_latch_wr,
  input  wire logic                pc_upper_latch_wr,
  input  wire logic                top_entry_upper_wr,
  input  wire logic                top_entry_high_wr,
  input  wire logic                top_entry_low_wr,
  input  wire logic                stack_ptr_wr,
  input  wire logic [BYTE_W-1:0]   wdata,
  // program memory
  input  wire logic [WORD_W-1:0]   mem_rdata,
  output logic      [PC_W-1:0]     mem_addr,
  output logic      [WORD_W-1:0]   instr_word,
  // counter and latches
  output logic      [PC_W-1:0]     pc_value,
  output logic      [BYTE_W-1:0]   pc_high_latch,
  output logic      [UPPER_W-1:0]  pc_upper_latch,
  // stack view
  output logic      [UPPER_W-1:0]  top_entry_upper,
  output logic      [BYTE_W-1:0]   top_entry_high,
  output logic      [BYTE_W-1:0]   top_entry_low,
  output logic      [BYTE_W-1:0]   return_stack_pointer,
  output logic                     stack_full_flag,
  output logic                     stack_underflow_flag,
  // configuration and status
  output logic      [WORD_W-1:0]   config_word_one,
  output logic      [WORD_W-1:0]   config_word_two,
  output logic      [WORD_W-1:0]   config_word_three,
  output logic                     stack_fault_reset_enable,
  output logic                     config_busy,
  output logic                     stack_reset_pulse
);
  localparam logic [PC_W-1:0] CFG_BASE = MEM_BYTES - CFG_AREA;

  load_state_t       load_state_reg;
  logic [PC_W-1:0]   pc_reg;
  logic [PC_W-1:0]   pc_next;
  logic [PTR_W-1:0]  ptr_reg;
  logic [PTR_W-1:0]  ptr_next;
  logic [PC_W-1:0]   tos_reg;
  logic [PC_W-1:0]   mem_addr_reg;
  logic [WORD_W-1:0] instr_reg;
  logic [WORD_W-1:0] cfg1_reg;
  logic [WORD_W-1:0] cfg2_reg;
  logic [WORD_W-1:0] cfg3_reg;
  logic [BYTE_W-1:0] high_latch_reg;
  logic [UPPER_W-1:0] upper_latch_reg;
  logic              full_reg;
  logic              unf_reg;
  logic              busy_reg;
  logic              fault_pulse_reg;
  logic              run;
  logic              do_push;
  logic              do_pop;
  logic              fault_en;
  logic              fault_now;
  logic              restart_now;
  logic              full_set;
  logic              unf_set;
  logic              tos_wr;
  logic [WORD_W-1:0] fetch_data;
  logic [PC_W-1:0]   push_val;
  logic [PC_W-1:0]   tos_merge;

  stack_port_if stk ();

  return_stack_store #(
    .DEPTH (STK_DEPTH)
  ) u_store (
    .clk  (clk),
    .port (stk)
  );

  program_fetch_gate #(
    .MEM_BYTES (MEM_BYTES)
  ) u_gate (
    .addr     (mem_addr_reg),
    .raw_data (mem_rdata),
    .data     (fetch_data)
  );

  assign fault_en = cfg1_reg[FAULT_EN_BIT];
  assign run      = (load_state_reg == CORE_RUN) && !soft_reset;
  assign do_push  = run && (int_high_ack || int_low_ack || op_call || op_relative_call); // RQ13
  assign do_pop   = run && !do_push && (op_return || op_return_with_literal || op_return_from_interrupt ||
                    (extended_enable && (op_add_and_unlink || op_subtract_and_unlink))); // RQ13
  assign tos_wr   = top_entry_upper_wr || top_entry_high_wr || top_entry_low_wr;
  // interrupts return to the pending instruction, calls past themselves
  assign push_val = (int_high_ack || int_low_ack) ? pc_reg : pc_add(pc_reg, PC_STEP);
  assign restart_now = soft_reset || fault_now;

  always_comb begin
    tos_merge = tos_reg;
    if (top_entry_upper_wr) begin
      tos_merge[PC_W-1:2*BYTE_W] = wdata[UPPER_W-1:0];
    end
    if (top_entry_high_wr) begin
      tos_merge[2*BYTE_W-1:BYTE_W] = wdata;
    end
    if (top_entry_low_wr) begin
      tos_merge[BYTE_W-1:0] = wdata;
    end
  end

  // next counter, pointer and stack write; one request per cycle, pushes first
  always_comb begin
    pc_next    = pc_reg;
    ptr_next   = ptr_reg;
    stk.we     = 1'b0;
    stk.widx   = ptr_reg;
    stk.wdata  = tos_merge;
    full_set   = 1'b0;
    unf_set    = 1'b0;
    fault_now  = 1'b0;
    if (do_push) begin
      if (int_high_ack) begin
        pc_next = VEC_HIGH; // RQ4
      end else if (int_low_ack) begin
        pc_next = VEC_LOW; // RQ4
      end else begin
        pc_next = target_addr & PC_ALIGN; // RQ11
      end
      if (ptr_reg == STK_TOP) begin
        full_set  = 1'b1; // RQ22
        fault_now = fault_en; // RQ23
      end else begin
        ptr_next  = ptr_reg + STK_STEP; // RQ15
        stk.we    = 1'b1;
        stk.widx  = ptr_reg + STK_STEP; // RQ15
        stk.wdata = push_val;
        if (ptr_reg == STK_LAST_FREE) begin
          full_set  = 1'b1; // RQ19
          fault_now = fault_en; // RQ23
        end
      end
    end else if (do_pop) begin
      if (ptr_reg == STK_EMPTY) begin
        pc_next   = VEC_RESET; // RQ24
        unf_set   = 1'b1; // RQ24
        fault_now = fault_en; // RQ24
      end else begin
        pc_next  = tos_reg & PC_ALIGN; // RQ16
        ptr_next = ptr_reg - STK_STEP; // RQ16
      end
    end else if (run && op_goto) begin
      pc_next = target_addr & PC_ALIGN; // RQ11
    end else if (run && pc_low_wr) begin
      pc_next = {upper_latch_reg, high_latch_reg, wdata & LOW_ALIGN}; // RQ8
    end else if (run && op_advance) begin
      pc_next = pc_add(pc_reg, PC_STEP); // RQ10
    end else if (run && stack_ptr_wr) begin
      ptr_next = wdata[PTR_W-1:0]; // RQ18
    end else if (run && tos_wr && ptr_reg != STK_EMPTY) begin
      stk.we = 1'b1; // RQ21
    end
    if (restart_now) begin
      pc_next  = VEC_RESET; // RQ3
      ptr_next = STK_EMPTY; // RQ17
    end
  end

  assign stk.ridx = ptr_next; // RQ26

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pc_reg  <= VEC_RESET; // RQ3
      ptr_reg <= STK_EMPTY; // RQ17
    end else begin
      pc_reg  <= pc_next; // RQ1
      ptr_reg <= ptr_next;
    end
  end

  // top entry follows the pointer, including a write landing there this cycle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tos_reg <= PC_ZERO;
    end else if (ptr_next == STK_EMPTY) begin
      tos_reg <= PC_ZERO; // RQ17
    end else if (stk.we && stk.widx == ptr_next) begin
      tos_reg <= stk.wdata; // RQ21
    end else begin
      tos_reg <= stk.rdata; // RQ26
    end
  end

  // calls and returns never reach the latches
  always_ff @(posedge clk or negedge resetn) begin // RQ14
    if (!resetn) begin
      high_latch_reg  <= BYTE_ZERO;
      upper_latch_reg <= UPPER_W'(BYTE_ZERO);
    end else if (restart_now) begin
      high_latch_reg  <= BYTE_ZERO;
      upper_latch_reg <= UPPER_W'(BYTE_ZERO);
    end else if (run && pc_low_rd) begin
      high_latch_reg  <= pc_reg[2*BYTE_W-1:BYTE_W]; // RQ9
      upper_latch_reg <= pc_reg[PC_W-1:2*BYTE_W]; // RQ9
    end else begin
      if (run && pc_high_latch_wr) begin
        high_latch_reg <= wdata; // RQ7
      end
      if (run && pc_upper_latch_wr) begin
        upper_latch_reg <= wdata[UPPER_W-1:0]; // RQ7
      end
    end
  end

  // only power-on clears the flags besides software; a set beats a clear
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      full_reg <= 1'b0;
      unf_reg  <= 1'b0;
    end else begin
      full_reg <= full_set || (full_reg && !(run && stack_ptr_wr && !wdata[PTR_FULL_BIT])); // RQ25
      unf_reg  <= unf_set || (unf_reg && !(run && stack_ptr_wr && !wdata[PTR_UNF_BIT])); // RQ25
    end
  end

  // configuration copy, then normal fetch on the counter
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      load_state_reg <= CFG_WORD1;
      mem_addr_reg   <= CFG_BASE;
      cfg1_reg       <= CFG_RESET;
      cfg2_reg       <= CFG_RESET;
      cfg3_reg       <= CFG_RESET;
      instr_reg      <= FETCH_ZERO;
    end else if (restart_now) begin
      load_state_reg <= CFG_WORD1; // RQ5
      mem_addr_reg   <= CFG_BASE; // RQ5
      instr_reg      <= FETCH_ZERO;
    end else begin
      case (load_state_reg)
        CFG_WORD1: begin
          cfg1_reg       <= fetch_data; // RQ6
          mem_addr_reg   <= CFG_BASE + CFG_STEP;
          load_state_reg <= CFG_WORD2;
        end
        CFG_WORD2: begin
          cfg2_reg       <= fetch_data; // RQ6
          mem_addr_reg   <= CFG_BASE + CFG_STEP + CFG_STEP;
          load_state_reg <= CFG_WORD3;
        end
        CFG_WORD3: begin
          cfg3_reg       <= fetch_data; // RQ6
          mem_addr_reg   <= pc_reg;
          load_state_reg <= CORE_RUN;
        end
        default: begin
          instr_reg    <= fetch_data; // RQ2
          mem_addr_reg <= pc_next;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      busy_reg        <= 1'b1;
      fault_pulse_reg <= 1'b0;
    end else begin
      busy_reg        <= restart_now || (load_state_reg != CORE_RUN && load_state_reg != CFG_WORD3);
      fault_pulse_reg <= fault_now; // RQ23
    end
  end

  assign mem_addr                 = mem_addr_reg;
  assign instr_word               = instr_reg;
  assign pc_value                 = pc_reg;
  assign pc_high_latch            = high_latch_reg;
  assign pc_upper_latch           = upper_latch_reg;
  assign top_entry_upper          = tos_reg[PC_W-1:2*BYTE_W];
  assign top_entry_high           = tos_reg[2*BYTE_W-1:BYTE_W];
  assign top_entry_low            = tos_reg[BYTE_W-1:0];
  assign return_stack_pointer     = {full_reg, unf_reg, 1'b0, ptr_reg}; // RQ25
  assign stack_full_flag          = full_reg;
  assign stack_underflow_flag     = unf_reg;
  assign config_word_one          = cfg1_reg;
  assign config_word_two          = cfg2_reg;
  assign config_word_three        = cfg3_reg;
  assign stack_fault_reset_enable = cfg1_reg[FAULT_EN_BIT];
  assign config_busy              = busy_reg;
  assign stack_reset_pulse        = fault_pulse_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_cfg_load;
    busy_reg [*3] ##1 !busy_reg;
  endsequence

  sequence s_push_ok;
    do_push && !fault_now && ptr_reg != STK_TOP;
  endsequence

  property p_reset_vector;
    soft_reset |=> pc_reg == VEC_RESET && ptr_reg == STK_EMPTY;
  endproperty
  a_reset_vector: assert property (p_reset_vector) else $error("reset did not vector to zero"); // RQ3

  property p_high_vector;
    run && int_high_ack |=> pc_reg == VEC_HIGH || $past(fault_now);
  endproperty
  a_high_vector: assert property (p_high_vector) else $error("high interrupt vector wrong"); // RQ4

  property p_advance;
    run && op_advance && !do_push && !do_pop && !op_goto && !pc_low_wr |=> pc_reg == pc_add($past(pc_reg), PC_STEP);
  endproperty
  a_advance: assert property (p_advance) else $error("sequential fetch did not add two"); // RQ10

  property p_align;
    pc_reg[0] == 1'b0;
  endproperty
  a_align: assert property (p_align) else $error("counter bit zero set"); // RQ10

  property p_push;
    s_push_ok |=> ptr_reg == $past(ptr_reg) + STK_STEP && tos_reg == $past(push_val);
  endproperty
  a_push: assert property (p_push) else $error("push pointer or value wrong"); // RQ15

  property p_pop;
    do_pop && ptr_reg != STK_EMPTY |=> pc_reg == ($past(tos_reg) & PC_ALIGN) && ptr_reg == $past(ptr_reg) - STK_STEP;
  endproperty
  a_pop: assert property (p_pop) else $error("pop did not restore counter"); // RQ16

  property p_underflow;
    do_pop && ptr_reg == STK_EMPTY |=> unf_reg && pc_reg == VEC_RESET && ptr_reg == STK_EMPTY;
  endproperty
  a_underflow: assert property (p_underflow) else $error("underflow handling wrong"); // RQ24

  property p_full_stick;
    do_push && ptr_reg == STK_TOP && !fault_en |=> ptr_reg == STK_TOP && full_reg;
  endproperty
  a_full_stick: assert property (p_full_stick) else $error("full stack pointer moved"); // RQ22

  property p_low_write;
    run && pc_low_wr && !do_push && !do_pop && !op_goto |=>
      pc_reg[PC_W-1:BYTE_W] == {$past(upper_latch_reg), $past(high_latch_reg)};
  endproperty
  a_low_write: assert property (p_low_write) else $error("latches not loaded on low byte write"); // RQ8

  property p_cfg_load;
    restart_now |=> s_cfg_load;
  endproperty
  a_cfg_load: assert property (p_cfg_load) else $error("configuration copy length wrong"); // RQ5

  property p_fault_reset;
    fault_now |=> stack_reset_pulse && ptr_reg == STK_EMPTY && (full_reg || unf_reg);
  endproperty
  a_fault_reset: assert property (p_fault_reset) else $error("stack fault reset missing"); // RQ23
endmodule
`default_nettype wire

// File: test/prog_mem_model.sv
// program memory stand-in for the fetch path
`timescale 1ns/1ps
`default_nettype none
module prog_mem_model
  import pc_stack_pkg::*;
#(
  parameter logic [PC_W-1:0] MEM_BYTES = MEM_128K
) (
  // fetch address and first configuration word
  input  wire logic [PC_W-1:0]   addr,
  input  wire logic [WORD_W-1:0] cfg_one,
  // read word
  output logic      [WORD_W-1:0] rdata
);
  // no array past the top: inverted pattern, so a missing gate shows
  always_comb begin
    if (addr >= MEM_BYTES) begin
      rdata = ~(addr[16:1] ^ 16'h5a5a);
    end else if (addr == MEM_BYTES - CFG_AREA) begin
      rdata = cfg_one;
    end else begin
      rdata = addr[16:1] ^ 16'h5a5a;
    end
  end
endmodule
`default_nettype wire

// File: test/tb_top.sv
// self-checking bench for the program counter and return stack
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import pc_stack_pkg::*;
  logic              clk = 1'b0;
  logic              resetn = 1'b0;
  logic [19:0]       req = 20'h00000;
  logic              ext_en = 1'b0;
  logic [PC_W-1:0]   target = PC_ZERO;
  logic [BYTE_W-1:0] wdata = BYTE_ZERO;
  logic [WORD_W-1:0] cfg_one = CFG_RESET;
  logic [WORD_W-1:0] mem_rdata, instr_word, cw1, cw2, cw3;
  logic [PC_W-1:0]   mem_addr, pc_value, e_pc, e_stk [32];
  logic [BYTE_W-1:0] hl, th, tl, sp, e_hl;
  logic [UPPER_W-1:0] ul, tu, e_ul;
  logic [4:0]        e_ptr;
  logic              full, unf, fen, busy, spulse, e_full, e_unf;
  int                err_count = 0;
  int                tests_run = 0;
  int                seed = 57;
  localparam logic [PC_W-1:0] MEM_BYTES = MEM_128K;
  initial forever #25 clk = ~clk;
  program_counter_return_stack #(.MEM_BYTES(MEM_BYTES)) DUT (.clk(clk), .resetn(resetn), .soft_reset(req[19]),
    .op_advance(req[0]),
    .op_call(req[1]), .op_relative_call(req[2]), .op_goto(req[3]), .op_return(req[4]),
    .op_return_with_literal(req[5]), .op_return_from_interrupt(req[6]), .op_add_and_unlink(req[7]),
    .op_subtract_and_unlink(req[8]), .extended_enable(ext_en), .int_high_ack(req[9]), .int_low_ack(req[10]),
    .target_addr(target), .pc_low_wr(req[11]), .pc_low_rd(req[12]), .pc_high_latch_wr(req[13]),
    .pc_upper_latch_wr(req[14]), .top_entry_upper_wr(req[15]), .top_entry_high_wr(req[16]),
    .top_entry_low_wr(req[17]), .stack_ptr_wr(req[18]), .wdata(wdata), .mem_rdata(mem_rdata),
    .mem_addr(mem_addr), .instr_word(instr_word), .pc_value(pc_value), .pc_high_latch(hl),
    .pc_upper_latch(ul), .top_entry_upper(tu), .top_entry_high(th), .top_entry_low(tl),
    .return_stack_pointer(sp), .stack_full_flag(full), .stack_underflow_flag(unf), .config_word_one(cw1),
    .config_word_two(cw2), .config_word_three(cw3), .stack_fault_reset_enable(fen), .config_busy(busy),
    .stack_reset_pulse(spulse));
  prog_mem_model #(.MEM_BYTES(MEM_BYTES)) mem (.addr(mem_addr), .cfg_one(cfg_one), .rdata(mem_rdata));
  function automatic logic [WORD_W-1:0] word_at(input logic [PC_W-1:0] a);
    return a[16:1] ^ 16'h5a5a;
  endfunction
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // one-cycle request, then one idle cycle before the next
  task automatic issue(input int i, input logic [PC_W-1:0] t, input logic [BYTE_W-1:0] d);
    @(posedge clk);
    req <= 20'h00001 << i;
    target <= t;
    wdata <= d;
    @(posedge clk);
    req <= 20'h00000;
    #1;
  endtask
  task automatic check_state();
    check("pc", pc_value, e_pc);
    check("fetch address", mem_addr, e_pc);
    check("pointer", sp, {e_full, e_unf, 1'b0, e_ptr});
    check("top entry", {tu, th, tl}, e_stk[e_ptr]);
    check("latches", {ul, hl}, {e_ul, e_hl});
    check("flags", {full, unf}, {e_full, e_unf});
  endtask
  task automatic wait_ready();
    for (int n = 0; n < 20 && busy !== 1'b0; n++) begin
      @(posedge clk);
      #1;
    end
    check("config busy", busy, 1'b0);
  endtask
  task automatic do_reset(input logic [WORD_W-1:0] cfg);
    @(posedge clk);
    cfg_one <= cfg;
    resetn <= 1'b0;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    #1;
    e_pc = VEC_RESET;
    e_ptr = STK_EMPTY;
    {e_full, e_unf, e_hl, e_ul} = '0;
    foreach (e_stk[k]) e_stk[k] = PC_ZERO;
    wait_ready();
    check_state();
    check("config one", cw1, cfg);
    check("config two", cw2, word_at(MEM_BYTES - 21'h6));
    check("config three", cw3, word_at(MEM_BYTES - 21'h4));
    check("fault enable", fen, cfg[0]);
  endtask
  task automatic push(input int i, input logic [PC_W-1:0] t);
    logic [PC_W-1:0] v;
    v = (i >= 9) ? e_pc : ((e_pc + PC_STEP) & PC_ALIGN);
    issue(i, t, BYTE_ZERO);
    if (e_ptr < STK_TOP) begin
      e_ptr++;
      e_stk[e_ptr] = v;
      e_full = (e_ptr == STK_TOP);
    end
    e_pc = (i == 9) ? VEC_HIGH : (i == 10) ? VEC_LOW : (t & PC_ALIGN);
    if (cfg_one[0] && e_ptr == STK_TOP) begin
      check("fault reset pulse", spulse, 1'b1);
      {e_ptr, e_pc, e_hl, e_ul} = '0;
      wait_ready();
    end
    check_state();
  endtask
  task automatic pop(input int i);
    issue(i, PC_ZERO, BYTE_ZERO);
    if (i < 7 || ext_en) begin
      if (e_ptr == STK_EMPTY) begin
        e_pc = PC_ZERO;
        e_unf = 1'b1;
      end else begin
        e_pc = e_stk[e_ptr];
        e_ptr--;
      end
    end
    check_state();
  endtask
  initial begin
    #(50ns * 20000);
    err_count++;
    end_of_test();
  end
  initial begin
    do_reset(16'hfffe);
    issue(0, PC_ZERO, BYTE_ZERO);
    e_pc = e_pc + PC_STEP;
    check_state();
    issue(3, 21'h000ab1, BYTE_ZERO);
    e_pc = 21'h000ab0;
    check_state();
    @(posedge clk);
    #1;
    check("fetched word", instr_word, word_at(e_pc));
    issue(12, PC_ZERO, BYTE_ZERO);
    {e_ul, e_hl} = e_pc[20:8];
    check_state();
    issue(13, PC_ZERO, 8'h12);
    issue(14, PC_ZERO, 8'h01);
    issue(11, PC_ZERO, 8'h47);
    {e_hl, e_ul} = {8'h12, 5'h01};
    e_pc = {e_ul, e_hl, 8'h46};
    check_state();
    issue(3, MEM_BYTES + 21'h100, BYTE_ZERO);
    e_pc = MEM_BYTES + 21'h100;
    @(posedge clk);
    #1;
    check("fetch beyond memory", instr_word, FETCH_ZERO);
    for (int k = 0; k < 32; k++) begin
      push((k % 4 == 3) ? 9 + (k / 4) % 2 : 1 + k % 2, $random(seed) & 21'h00fffe);
    end
    issue(18, PC_ZERO, 8'h05);
    {e_ptr, e_full, e_unf} = {5'h05, 2'b00};
    check_state();
    issue(15, PC_ZERO, 8'h01);
    issue(16, PC_ZERO, 8'h23);
    issue(17, PC_ZERO, 8'h44);
    e_stk[5] = 21'h012344;
    pop(4);
    pop(7);
    ext_en <= 1'b1;
    while (e_ptr != STK_EMPTY) pop(4 + e_ptr % 5);
    pop(4);
    issue(19, PC_ZERO, BYTE_ZERO);
    {e_pc, e_ptr, e_hl, e_ul} = '0;
    wait_ready();
    check_state();
    do_reset(16'hffff);
    for (int k = 0; k < 31; k++) push(1, $random(seed) & 21'h00fffe);
    // entry 31 must still hold the address stored by the faulting push
    issue(18, PC_ZERO, 8'hdf);
    e_ptr = STK_TOP;
    check_state();
    end_of_test();
  end
endmodule
`default_nettype wire
